//--- rlpf_pkg.sv
// shared constants and types of the radio link packet framer
package rlpf_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_ADDR_LO = 8'h04;
  localparam logic [7:0] OFF_ADDR_HI = 8'h08;
  localparam logic [7:0] OFF_SWID = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_TXDATA = 8'h14;
  localparam logic [7:0] OFF_ACKDATA = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_RXDATA = 8'h20;
  localparam logic [7:0] OFF_RD_PAY_WIDTH = 8'h24;
  // config fields
  localparam int CFG_PRX = 0;
  localparam int CFG_CRC2 = 1;
  localparam int CFG_AW_LSB = 2;
  localparam int CFG_DYN = 4;
  localparam int CFG_ACKPAY = 5;
  localparam int CFG_AA = 6;
  localparam int CFG_PDYN = 7;
  localparam int CFG_RTL_LSB = 8;
  localparam int CFG_NOACK = 12;
  localparam logic [31:0] CFG_RST = 32'h0000034e;
  localparam logic [39:0] ADDR_RST = 40'h00_0000_0000;
  localparam logic [5:0] SWID_RST = 6'h00;
  localparam logic [1:0] AW_4B = 2'h2;
  localparam logic [1:0] AW_5B = 2'h3;
  // command bits
  localparam int CMD_START = 0;
  localparam int CMD_FLRX = 1;
  localparam int CMD_FLTX = 2;
  localparam int CMD_ACKCOMMIT = 3;
  localparam int CMD_STOP = 4;
  // status fields
  localparam int ST_RXR = 0;
  localparam int ST_TXD = 1;
  localparam int ST_MAXRT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_PID_LSB = 4;
  localparam int ST_RTC_LSB = 8;
  // framing
  localparam logic [7:0] PRE_ONE = 8'haa;
  localparam logic [7:0] PRE_ZERO = 8'h55;
  localparam logic [5:0] MAX_PAY = 6'h20;
  localparam logic [1:0] ACK_SLOTS = 2'h3;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] CRC8_INIT = 8'hff;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int BIT_NS = 500;
  localparam int BIT_CYC = BIT_NS * CLK_MHZ / 1000;
  localparam int ADDR_TMO_US = 250;
  localparam int ARD_US = 250;
  typedef enum logic [2:0] {S_IDLE, S_TX, S_WACK, S_ARD, S_LISTEN} rlpf_state_t;
  typedef enum logic [2:0] {T_PRE, T_ADR, T_PCF, T_PAY, T_CRC, T_END} rlpf_tph_t;
  typedef enum logic [2:0] {R_OFF, R_ADR, R_PCF, R_PAY, R_CRC} rlpf_rph_t;
endpackage

//--- rlpf_crc.sv
// serial msb-first crc engine, one or two bytes wide
`timescale 1ns/1ps
module rlpf_crc (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic init_i,
  input wire logic en_i,
  input wire logic bit_i,
  input wire logic wide_i,
  // result
  output logic [15:0] crc_o
);
  import rlpf_pkg::*;
  logic fb;
  assign fb = wide_i ? (crc_o[15] ^ bit_i) : (crc_o[7] ^ bit_i);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_o <= CRC16_INIT;
    end else if (init_i) begin
      crc_o <= wide_i ? CRC16_INIT : {8'h00, CRC8_INIT};
    end else if (en_i) begin
      if (wide_i) begin
        crc_o <= {crc_o[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
      end else begin
        crc_o <= {8'h00, crc_o[6:0], 1'b0} ^ {8'h00, (fb ? CRC8_POLY : 8'h00)};
      end
    end
  end
endmodule

//--- rlpf_top.sv
// radio link packet framer: assembly, disassembly, ack and retransmit
`timescale 1ns/1ps
module rlpf_top #(
  parameter int ADDR_TMO_CYC = rlpf_pkg::ADDR_TMO_US * rlpf_pkg::CLK_MHZ,
  parameter int ARD_CYC = rlpf_pkg::ARD_US * rlpf_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // modem transmit side
  output logic tx_en_o,
  output logic tx_stb_o,
  output logic tx_bit_o,
  // modem receive side
  output logic rx_en_o,
  input wire logic rx_sync_i,
  input wire logic rx_vld_i,
  input wire logic rx_bit_i
);
  import rlpf_pkg::*;

  rlpf_state_t st_q;
  rlpf_tph_t tph_q;
  rlpf_rph_t rph_q;
  logic [31:0] cfg_q;
  logic [39:0] addr_q;
  logic [5:0] swid_q;
  logic [7:0] tx_mem [0:31];
  logic [5:0] tx_cnt_q;
  logic tx_new_q;
  logic [1:0] pid_q;
  logic [7:0] ack_mem [0:95];
  logic [5:0] ack_len_q [0:2];
  logic [1:0] ack_wp_q, ack_rp_q, ack_n_q;
  logic [5:0] ack_fill_q;
  logic is_ack_q, ack_has_q;
  logic [8:0] bcnt_q, rcnt_q;
  logic [6:0] bt_q;
  logic [3:0] rtc_q;
  logic [15:0] tmr_q;
  logic [8:0] rpcf_q;
  logic [5:0] rlen_q;
  logic [15:0] rcrc_q;
  logic [7:0] rbyte_q;
  logic rdone_q, rgood_q;
  logic [7:0] rx_mem [0:31];
  logic rx_full_q;
  logic [5:0] rx_wid_q, rx_rp_q;
  logic [1:0] last_pid_q;
  logic [15:0] last_crc_q;
  logic last_ok_q;
  logic rxr_q, txd_q, mrt_q;
  logic [15:0] crc_val;

  // bus decode
  logic bus_req, wr, rd, cmd_wr;
  logic [7:0] a;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = bus_req & wb_we_i;
  assign rd = bus_req & ~wb_we_i;
  assign a = {wb_adr_i[7:2], 2'b00};
  assign cmd_wr = wr && a == OFF_CMD && wb_sel_i[0];

  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  // configuration view
  logic primary_receiver, crc2, aa, noack_tx, dyn_rx, ackpay_ok;
  logic [1:0] aw;
  logic [3:0] rtl;
  logic [5:0] awbits, amsb;
  assign primary_receiver = cfg_q[CFG_PRX];
  assign crc2 = cfg_q[CFG_CRC2];
  assign aa = cfg_q[CFG_AA];
  assign noack_tx = cfg_q[CFG_NOACK];
  assign dyn_rx = cfg_q[CFG_DYN] & cfg_q[CFG_PDYN];
  assign ackpay_ok = cfg_q[CFG_ACKPAY] & cfg_q[CFG_DYN];
  assign aw = cfg_q[CFG_AW_LSB +: 2];
  assign rtl = cfg_q[CFG_RTL_LSB +: 4];
  assign awbits = (aw == AW_5B) ? 6'd40 : (aw == AW_4B) ? 6'd32 : 6'd24;
  assign amsb = awbits - 6'd1;

  // transmit serializer
  logic tick, tx_fin, need_ack, cur_bit, tlast;
  logic [5:0] tx_len;
  logic [8:0] flen, tpcf;
  logic [7:0] pre, pbyte;
  logic [5:0] taidx;
  logic [3:0] cidx;
  assign tick = st_q == S_TX && bt_q == 7'd0;
  assign tx_fin = tick && tph_q == T_END;
  assign need_ack = aa & ~noack_tx;
  assign tx_len = is_ack_q ? (ack_has_q ? ack_len_q[ack_rp_q] : 6'd0) : tx_cnt_q;
  assign tpcf = {tx_len, (is_ack_q ? last_pid_q : pid_q), (~is_ack_q & noack_tx)};
  assign pre = addr_q[amsb] ? PRE_ONE : PRE_ZERO;
  assign pbyte = is_ack_q ? ack_mem[{ack_rp_q, bcnt_q[7:3]}] : tx_mem[bcnt_q[7:3]];
  assign taidx = amsb - bcnt_q[5:0];
  assign cidx = (crc2 ? 4'd15 : 4'd7) - bcnt_q[3:0];
  assign tlast = bcnt_q == flen - 9'd1;

  always_comb begin
    flen = 9'd8;
    cur_bit = 1'b0;
    unique case (tph_q)
      T_PRE: cur_bit = pre[3'd7 - bcnt_q[2:0]];
      T_ADR: begin
        flen = {3'b000, awbits};
        cur_bit = addr_q[taidx];
      end
      T_PCF: begin
        flen = 9'd9;
        cur_bit = tpcf[4'd8 - bcnt_q[3:0]];
      end
      T_PAY: begin
        flen = {tx_len[5:0], 3'b000};
        cur_bit = pbyte[3'd7 - bcnt_q[2:0]];
      end
      T_CRC: begin
        flen = crc2 ? 9'd16 : 9'd8;
        cur_bit = crc_val[cidx];
      end
      T_END: cur_bit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tph_q <= T_PRE;
      bcnt_q <= 9'd0;
      bt_q <= 7'd0;
      tx_stb_o <= 1'b0;
      tx_bit_o <= 1'b0;
      tx_en_o <= 1'b0;
    end else if (st_q != S_TX) begin
      tph_q <= T_PRE;
      bcnt_q <= 9'd0;
      bt_q <= 7'd0;
      tx_stb_o <= 1'b0;
      tx_en_o <= 1'b0;
    end else begin
      tx_en_o <= tph_q != T_END;
      tx_stb_o <= tick && tph_q != T_END;
      if (tick) begin
        bt_q <= 7'(BIT_CYC - 1);
        tx_bit_o <= cur_bit;
        if (tph_q != T_END && tlast) begin
          bcnt_q <= 9'd0;
          unique case (tph_q)
            T_PRE: tph_q <= T_ADR;
            T_ADR: tph_q <= T_PCF;
            T_PCF: tph_q <= (tx_len == 6'd0) ? T_CRC : T_PAY;
            T_PAY: tph_q <= T_CRC;
            default: tph_q <= T_END;
          endcase
        end else begin
          bcnt_q <= bcnt_q + 9'd1;
        end
      end else begin
        bt_q <= bt_q - 7'd1;
      end
    end
  end

  // receive deserializer
  logic rx_on, rlast, rx_good_cmp;
  logic [8:0] rflen, pcf_full;
  logic [5:0] len_d, raidx;
  logic [15:0] rc_m, rc_next;
  assign rx_on = st_q == S_WACK || st_q == S_LISTEN;
  assign pcf_full = {rpcf_q[7:0], rx_bit_i};
  assign len_d = dyn_rx ? pcf_full[8:3] : swid_q;
  assign raidx = amsb - rcnt_q[5:0];
  assign rlast = rcnt_q == rflen - 9'd1;
  assign rc_next = {rcrc_q[14:0], rx_bit_i};
  assign rx_good_cmp = crc2 ? (rc_next == crc_val) : (rc_next[7:0] == crc_val[7:0]);
  assign rc_m = crc2 ? rcrc_q : {8'h00, rcrc_q[7:0]};

  always_comb begin
    unique case (rph_q)
      R_ADR: rflen = {3'b000, awbits};
      R_PCF: rflen = 9'd9;
      R_PAY: rflen = {rlen_q, 3'b000};
      R_CRC: rflen = crc2 ? 9'd16 : 9'd8;
      default: rflen = 9'd1;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rph_q <= R_OFF;
      rcnt_q <= 9'd0;
      rpcf_q <= 9'd0;
      rlen_q <= 6'd0;
      rcrc_q <= 16'h0000;
      rbyte_q <= 8'h00;
      rdone_q <= 1'b0;
      rgood_q <= 1'b0;
    end else begin
      rdone_q <= 1'b0;
      if (!rx_on) begin
        rph_q <= R_OFF;
      end else if (rph_q == R_OFF) begin
        rcnt_q <= 9'd0;
        if (rx_sync_i) rph_q <= R_ADR;
      end else if (rx_vld_i) begin
        rcnt_q <= rlast ? 9'd0 : rcnt_q + 9'd1;
        unique case (rph_q)
          R_ADR: begin
            if (rx_bit_i != addr_q[raidx]) rph_q <= R_OFF;
            else if (rlast) rph_q <= R_PCF;
          end
          R_PCF: begin
            rpcf_q <= pcf_full;
            if (rlast) begin
              rlen_q <= len_d;
              rph_q <= (len_d == 6'd0) ? R_CRC : R_PAY;
            end
          end
          R_PAY: begin
            rbyte_q <= {rbyte_q[6:0], rx_bit_i};
            if (rlast) rph_q <= R_CRC;
          end
          default: begin
            rcrc_q <= rc_next;
            if (rlast) begin
              rph_q <= R_OFF;
              rdone_q <= 1'b1;
              rgood_q <= rx_good_cmp;
            end
          end
        endcase
      end
    end
  end

  // payload lands only while the host buffer is free, so a full buffer drops packets
  always_ff @(posedge mclk_i) begin
    if (rx_on && rph_q == R_PAY && rx_vld_i && rcnt_q[2:0] == 3'd7 && !rcnt_q[8]
        && !rx_full_q) begin
      rx_mem[rcnt_q[7:3]] <= {rbyte_q[6:0], rx_bit_i};
    end
  end

  // shared crc engine: link is half duplex
  logic crc_init, crc_en, crc_bit;
  assign crc_init = (st_q == S_TX) ? (tph_q == T_PRE) : (rph_q == R_OFF);
  assign crc_en = (st_q == S_TX) ? (tick && (tph_q == T_ADR || tph_q == T_PCF ||
                  tph_q == T_PAY)) : (rx_on && rx_vld_i && (rph_q == R_ADR ||
                  rph_q == R_PCF || rph_q == R_PAY));
  assign crc_bit = (st_q == S_TX) ? cur_bit : rx_bit_i;

  rlpf_crc u_crc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .init_i(crc_init),
    .en_i(crc_en),
    .bit_i(crc_bit),
    .wide_i(crc2),
    .crc_o(crc_val)
  );

  // transaction events
  logic dup, ev_commit, ev_acked, ev_txok, wait_end, fail, ev_maxrt, ev_ack_go, ack_pop;
  assign dup = last_ok_q && rpcf_q[2:1] == last_pid_q && rc_m == last_crc_q;
  assign ev_commit = rdone_q && rgood_q && !rx_full_q &&
                     ((st_q == S_LISTEN && !dup) || (st_q == S_WACK && rlen_q != 6'd0));
  assign ev_acked = st_q == S_WACK && rdone_q && rgood_q;
  assign ev_txok = ev_acked || (tx_fin && !is_ack_q && !need_ack);
  assign wait_end = rdone_q || (rph_q == R_OFF && tmr_q >= 16'(ADDR_TMO_CYC)) ||
                    tmr_q >= 16'(ARD_CYC);
  assign fail = st_q == S_WACK && !ev_acked && wait_end;
  assign ev_maxrt = fail && rtc_q == rtl;
  assign ev_ack_go = st_q == S_LISTEN && rdone_q && rgood_q && aa && !rpcf_q[0];
  assign ack_pop = tx_fin && is_ack_q && ack_has_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      is_ack_q <= 1'b0;
      ack_has_q <= 1'b0;
      rtc_q <= 4'd0;
      tmr_q <= 16'd0;
      rx_en_o <= 1'b0;
    end else begin
      rx_en_o <= rx_on;
      unique case (st_q)
        S_IDLE: begin
          if (cmd_wr && wb_dat_i[CMD_START]) begin
            is_ack_q <= 1'b0;
            rtc_q <= 4'd0;
            st_q <= primary_receiver ? S_LISTEN : S_TX;
          end
        end
        S_LISTEN: begin
          if (cmd_wr && wb_dat_i[CMD_STOP]) begin
            st_q <= S_IDLE;
          end else if (ev_ack_go) begin
            is_ack_q <= 1'b1;
            ack_has_q <= ackpay_ok && ack_n_q != 2'd0;
            st_q <= S_TX;
          end
        end
        S_TX: begin
          tmr_q <= 16'd0;
          if (tx_fin) begin
            if (is_ack_q) st_q <= S_LISTEN;
            else st_q <= need_ack ? S_WACK : S_IDLE;
          end
        end
        S_WACK: begin
          tmr_q <= tmr_q + 16'd1;
          if (ev_acked || ev_maxrt) st_q <= S_IDLE;
          else if (fail) st_q <= S_ARD;
        end
        S_ARD: begin
          tmr_q <= tmr_q + 16'd1;
          if (tmr_q >= 16'(ARD_CYC)) begin
            rtc_q <= rtc_q + 4'd1;
            st_q <= S_TX;
          end
        end
      endcase
    end
  end

  // copy detection memory
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      last_pid_q <= 2'd0;
      last_crc_q <= 16'h0000;
      last_ok_q <= 1'b0;
    end else if (st_q == S_LISTEN && rdone_q && rgood_q && !dup && !rx_full_q) begin
      last_pid_q <= rpcf_q[2:1];
      last_crc_q <= rc_m;
      last_ok_q <= 1'b1;
    end
  end

  // host receive buffer; a commit beats a flush in the same cycle
  logic rx_pop;
  assign rx_pop = rd && a == OFF_RXDATA && rx_full_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_full_q <= 1'b0;
      rx_wid_q <= 6'd0;
      rx_rp_q <= 6'd0;
    end else if (ev_commit) begin
      rx_full_q <= 1'b1;
      rx_wid_q <= rlen_q;
      rx_rp_q <= 6'd0;
    end else if (cmd_wr && wb_dat_i[CMD_FLRX]) begin
      rx_full_q <= 1'b0;
    end else if (rx_pop) begin
      rx_rp_q <= rx_rp_q + 6'd1;
      if (rx_rp_q + 6'd1 >= rx_wid_q || rx_rp_q + 6'd1 >= MAX_PAY) rx_full_q <= 1'b0;
    end
  end

  // status flags: hardware set wins over write-one-to-clear
  logic st_wr;
  assign st_wr = wr && a == OFF_STATUS && wb_sel_i[0];
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rxr_q <= 1'b0;
      txd_q <= 1'b0;
      mrt_q <= 1'b0;
    end else begin
      rxr_q <= ev_commit | (rxr_q & ~(st_wr & wb_dat_i[ST_RXR]));
      txd_q <= ev_txok | (txd_q & ~(st_wr & wb_dat_i[ST_TXD]));
      mrt_q <= ev_maxrt | (mrt_q & ~(st_wr & wb_dat_i[ST_MAXRT]));
    end
  end

  // transmit payload buffer and packet identity
  logic tx_wr, fltx;
  assign tx_wr = wr && a == OFF_TXDATA && wb_sel_i[0] && st_q == S_IDLE && tx_cnt_q < MAX_PAY;
  assign fltx = cmd_wr && wb_dat_i[CMD_FLTX];
  always_ff @(posedge mclk_i) begin
    if (tx_wr) tx_mem[tx_cnt_q[4:0]] <= wb_dat_i[7:0];
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt_q <= 6'd0;
      tx_new_q <= 1'b1;
      pid_q <= 2'd0;
    end else if (ev_txok || (fltx && st_q == S_IDLE)) begin
      tx_cnt_q <= 6'd0;
      tx_new_q <= 1'b1;
    end else if (tx_wr) begin
      tx_cnt_q <= tx_cnt_q + 6'd1;
      tx_new_q <= 1'b0;
      if (tx_new_q) pid_q <= pid_q + 2'd1;
    end
  end

  // pending ack payload slots, single sender so plain fifo order
  logic ack_wr, ack_cm;
  assign ack_wr = wr && a == OFF_ACKDATA && wb_sel_i[0] && ack_n_q < ACK_SLOTS &&
                  ack_fill_q < MAX_PAY;
  assign ack_cm = cmd_wr && wb_dat_i[CMD_ACKCOMMIT] && ack_n_q < ACK_SLOTS;
  always_ff @(posedge mclk_i) begin
    if (ack_wr) ack_mem[{ack_wp_q, ack_fill_q[4:0]}] <= wb_dat_i[7:0];
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) ack_len_q[i] <= 6'd0;
      ack_wp_q <= 2'd0;
      ack_rp_q <= 2'd0;
      ack_n_q <= 2'd0;
      ack_fill_q <= 6'd0;
    end else if (fltx && !(st_q == S_TX && is_ack_q)) begin
      ack_wp_q <= 2'd0;
      ack_rp_q <= 2'd0;
      ack_n_q <= 2'd0;
      ack_fill_q <= 6'd0;
    end else begin
      if (ack_wr) ack_fill_q <= ack_fill_q + 6'd1;
      if (ack_cm) begin
        ack_len_q[ack_wp_q] <= ack_fill_q;
        ack_wp_q <= (ack_wp_q == 2'd2) ? 2'd0 : ack_wp_q + 2'd1;
        ack_fill_q <= 6'd0;
      end
      if (ack_pop) ack_rp_q <= (ack_rp_q == 2'd2) ? 2'd0 : ack_rp_q + 2'd1;
      if (ack_cm && !ack_pop) ack_n_q <= ack_n_q + 2'd1;
      else if (ack_pop && !ack_cm) ack_n_q <= ack_n_q - 2'd1;
    end
  end

  // wishbone registers and answer, one cycle after the request
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
      addr_q <= ADDR_RST;
      swid_q <= SWID_RST;
    end else if (wr) begin
      case (a)
        OFF_CFG: cfg_q <= wmask(cfg_q, wb_dat_i, wb_sel_i);
        OFF_ADDR_LO: addr_q[31:0] <= wmask(addr_q[31:0], wb_dat_i, wb_sel_i);
        OFF_ADDR_HI: if (wb_sel_i[0]) addr_q[39:32] <= wb_dat_i[7:0];
        OFF_SWID: if (wb_sel_i[0]) swid_q <= wb_dat_i[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (rd) begin
        case (a)
          OFF_CFG: wb_dat_o <= cfg_q;
          OFF_ADDR_LO: wb_dat_o <= addr_q[31:0];
          OFF_ADDR_HI: wb_dat_o <= {24'h000000, addr_q[39:32]};
          OFF_SWID: wb_dat_o <= {26'h0000000, swid_q};
          OFF_STATUS: wb_dat_o <= {20'h00000, rtc_q, 2'b00, pid_q, (st_q != S_IDLE),
                                   mrt_q, txd_q, rxr_q};
          OFF_RXDATA: wb_dat_o <= rx_full_q ? {24'h000000, rx_mem[rx_rp_q[4:0]]} : 32'h0;
          OFF_RD_PAY_WIDTH: wb_dat_o <= {26'h0000000, rx_wid_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- rlpf_top_checker.sv
// concurrent checks on the framer's top-level ports
`timescale 1ns/1ps
module rlpf_top_checker #(
  parameter int ADDR_TMO_CYC = 31250,
  parameter int ARD_CYC = 31250
) (
  // clock and reset
  input logic mclk_i,
  input logic rst_i,
  // wishbone
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // modem
  input logic tx_en_o,
  input logic tx_stb_o,
  input logic tx_bit_o,
  input logic rx_en_o,
  input logic rx_sync_i,
  input logic rx_vld_i,
  input logic rx_bit_i
);
  logic [8:0] nbit_q;
  logic last_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // air bits counted per frame, so framing is checked without a decoder
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nbit_q <= '0;
      last_q <= 1'b0;
    end else if (!tx_en_o) begin
      nbit_q <= '0;
    end else if (tx_stb_o) begin
      nbit_q <= nbit_q + 9'h1;
      last_q <= tx_bit_o;
    end
  end
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h09
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  chk_stb_gap: assert property (tx_stb_o |=> !tx_stb_o [*8])
    else $error("air bits too close");
  chk_stb_in_frame: assert property (tx_stb_o |-> tx_en_o)
    else $error("air bit outside frame");
  chk_bit_hold: assert property (tx_en_o && !tx_stb_o |-> $stable(tx_bit_o))
    else $error("air bit moved between strobes");
  chk_preamble_alt: assert property (tx_stb_o && nbit_q inside {[9'd1:9'd8]}
    |-> tx_bit_o != last_q) else $error("preamble not alternating");
  chk_frame_len: assert property ($fell(tx_en_o) |-> nbit_q inside {[9'd49:9'd329]})
    else $error("frame length out of range");
  chk_no_listen_tx: assert property (tx_stb_o |-> !rx_en_o)
    else $error("listening while sending");
endmodule
bind rlpf_top rlpf_top_checker #(.ADDR_TMO_CYC(ADDR_TMO_CYC), .ARD_CYC(ARD_CYC)) chk_inst (.*);

//--- rlpf_peer.sv
// behavioural peer link layer: captures air bits, plays packets back
`timescale 1ns/1ps
module rlpf_peer (
  // clock
  input logic mclk_i,
  // from the framer's transmitter
  input logic tx_stb_i,
  input logic tx_bit_i,
  // to the framer's receiver
  output logic rx_sync_o,
  output logic rx_vld_o,
  output logic rx_bit_o
);
  logic got[$];
  initial begin
    rx_sync_o = 0;
    rx_vld_o = 0;
    rx_bit_o = 0;
  end
  always @(posedge mclk_i) if (tx_stb_i === 1'b1) got.push_back(tx_bit_i);
  // gap of 2 is a prompt peer; line toggles so a stale bit never looks valid
  task automatic send(input logic [127:0] v, input int n, input int gap);
    @(posedge mclk_i);
    rx_sync_o <= 1;
    @(posedge mclk_i);
    rx_sync_o <= 0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge mclk_i);
      rx_vld_o <= 1;
      rx_bit_o <= v[i];
      @(posedge mclk_i);
      rx_vld_o <= 0;
      repeat (gap - 2) begin
        @(posedge mclk_i);
        rx_bit_o <= ~rx_bit_o;
      end
    end
  endtask
endmodule

//--- rlpf_top_tb.sv
// self-checking bench of the radio link packet framer
`timescale 1ns/1ps
`define CHK(g,e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t: got %h exp %h", $time, g, e); end end
module rlpf_top_tb;
  import rlpf_pkg::*;
  logic mclk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic ack, tx_en, tx_stb, tx_bit, rx_en, rx_sync, rx_vld, rx_bit;
  int fails = 0, checked = 0, cycles = 0;
  integer seed = 32'h7dd9;
  logic [23:0] addr;
  logic [15:0] pay;
  logic [127:0] body, frm;
  logic [7:0] crc, ackb;
  rlpf_top #(.ADDR_TMO_CYC(600), .ARD_CYC(600)) rlpf_top_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_en_o(tx_en), .tx_stb_o(tx_stb), .tx_bit_o(tx_bit), .rx_en_o(rx_en),
    .rx_sync_i(rx_sync), .rx_vld_i(rx_vld), .rx_bit_i(rx_bit));
  rlpf_peer rlpf_peer_inst (.mclk_i(mclk_i), .tx_stb_i(tx_stb), .tx_bit_i(tx_bit),
    .rx_sync_o(rx_sync), .rx_vld_o(rx_vld), .rx_bit_o(rx_bit));
  initial forever #4 mclk_i = ~mclk_i;
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do @(posedge mclk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  function automatic logic [7:0] crc8(input logic [127:0] v, input int n);
    logic [7:0] c;
    c = CRC8_INIT;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC8_POLY : 8'h00);
    return c;
  endfunction
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 0;
    wb(0, OFF_CFG, 0);
    `CHK(q, CFG_RST)
    wb(0, 8'hfc, 0);
    `CHK(q, 32'h0)
    wb(1, OFF_CFG, 0);
    for (int i = 0; i < 2; i++) begin
      addr = {i[0], 23'($random(seed))};
      pay = 16'($random(seed));
      wb(1, OFF_ADDR_LO, {8'h00, addr});
      wb(1, OFF_TXDATA, {24'h0, pay[15:8]});
      wb(1, OFF_TXDATA, {24'h0, pay[7:0]});
      wb(1, OFF_CMD, 32'h1);
      q = 0;
      while (q[ST_TXD] !== 1'b1) wb(0, OFF_STATUS, 0);
      wb(1, OFF_STATUS, 32'h2);
      body = {addr, 6'd2, 2'(i + 1), 1'b0, pay};
      crc = crc8(body, 49);
      frm = {addr[23] ? PRE_ONE : PRE_ZERO, body[48:0], crc};
      `CHK(rlpf_peer_inst.got.size(), 65)
      for (int b = 0; b < 65; b++) `CHK(rlpf_peer_inst.got[b], frm[64 - b])
      rlpf_peer_inst.got.delete();
    end
    wb(1, OFF_CFG, 32'h1);
    wb(1, OFF_SWID, 32'h2);
    wb(1, OFF_CMD, 32'h1);
    while (rx_en !== 1'b1) @(posedge mclk_i);
    body = {addr, 6'd2, 2'd1, 1'b0, pay};
    for (int k = 0; k < 3; k++) begin
      crc = crc8(body, 49) ^ {7'h0, k == 2};
      rlpf_peer_inst.send({body[48:0], crc}, 57, k ? 2 : BIT_CYC);
      repeat (4) @(posedge mclk_i);
      wb(0, OFF_STATUS, 0);
      `CHK(q[ST_RXR], k == 0)
      for (int j = 0; j < 2; j++) begin
        wb(0, OFF_RXDATA, 0);
        `CHK(q[7:0], k ? 8'h00 : pay[15 - 8 * j -: 8])
      end
      wb(1, OFF_STATUS, 32'h1);
    end
    wb(1, OFF_CFG, 32'hf1);
    ackb = 8'($random(seed));
    wb(1, OFF_ACKDATA, {24'h0, ackb});
    wb(1, OFF_CMD, 32'h8);
    // dynamic length packets; the second asks for no ack, so no frame may follow
    for (int k = 0; k < 2; k++) begin
      body = {addr, 6'd1, 2'(k + 2), k[0], pay[7:0]};
      crc = crc8(body, 41);
      rlpf_peer_inst.send({body[40:0], crc}, 49, 2);
      repeat (80) @(posedge mclk_i);
      while (rx_en !== 1'b1) @(posedge mclk_i);
      wb(0, OFF_RD_PAY_WIDTH, 0);
      `CHK(q[5:0], 6'd1)
      if (q[5:0] > MAX_PAY) wb(1, OFF_CMD, 32'h2);
      wb(0, OFF_RXDATA, 0);
      `CHK(q[7:0], pay[7:0])
      `CHK(rlpf_peer_inst.got.size(), k ? 0 : 57)
      frm = {addr[23] ? PRE_ONE : PRE_ZERO, addr, 6'd1, 2'd2, 1'b0, ackb, 8'h00};
      frm[7:0] = crc8(frm[48:8], 41);
      for (int b = 0; b < 57 && !k; b++) `CHK(rlpf_peer_inst.got[b], frm[56 - b])
      rlpf_peer_inst.got.delete();
    end
    tally_and_finish();
  end
endmodule
